//--- core/mbrs_pkg.sv
/*
 Constants, register map and enumerations shared by the serial function
 handler of the stepping-motor driver.
 Assumes a single 250 MHz clock and frames already stripped of slave address
 and CRC by the surrounding serial logic.
*/
package mbrs_pkg;

   // Clock and transmission wait timing.
   localparam int CLK_PERIOD_NS    = 4;
   localparam int WAIT_UNIT_NS     = 100000;
   localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [15:0] WAIT_MAX_UNITS = 16'h2710;

   // Frame buffer and query limits.
   localparam int BUF_BYTES = 26;
   localparam logic [15:0] MAX_REGS = 16'h000A;
   localparam logic [4:0]  ECHO_LEN = 5'h05;
   localparam logic [4:0]  EXC_LEN  = 5'h02;
   localparam logic [4:0]  MULTI_HDR = 5'h06;

   // Function codes and exception codes.
   localparam logic [7:0] FC_READ   = 8'h03;
   localparam logic [7:0] FC_WRITE1 = 8'h06;
   localparam logic [7:0] FC_DIAG   = 8'h08;
   localparam logic [7:0] FC_WRITEN = 8'h10;
   localparam logic [7:0] FC_EXC    = 8'h80;
   localparam logic [7:0] EXC_NONE  = 8'h00;
   localparam logic [7:0] EXC_FUNC  = 8'h01;
   localparam logic [7:0] EXC_ADDR  = 8'h02;
   localparam logic [7:0] EXC_DATA  = 8'h03;

   // Register addresses.
   localparam logic [15:0] ADDR_CMD      = 16'h001E;
   localparam logic [15:0] ADDR_FCLR     = 16'h0040;
   localparam logic [15:0] ADDR_PRESET   = 16'h0048;
   localparam logic [15:0] ADDR_CURRENT  = 16'h021E;
   localparam logic [15:0] ADDR_PROTOCOL = 16'h0380;
   localparam logic [15:0] ADDR_PARITY   = 16'h0381;
   localparam logic [15:0] ADDR_STOPBITS = 16'h0382;
   localparam logic [15:0] ADDR_TXWAIT   = 16'h0383;
   localparam logic [15:0] ADDR_START_MD = 16'h0384;
   localparam logic [15:0] ADDR_EXCITE_MD = 16'h0385;
   localparam logic [15:0] ADDR_IOSTOP_EN = 16'h0386;
   localparam logic [15:0] ADDR_DATANO_MD = 16'h0387;
   localparam logic [15:0] ADDR_HFR_MD   = 16'h0388;

   // Register indices in the storage array.
   localparam int NREG = 13;
   localparam logic [4:0] IDX_CMD = 5'h00, IDX_FCLR = 5'h01, IDX_PRESET = 5'h02;
   localparam logic [4:0] IDX_CURRENT = 5'h03, IDX_PROTOCOL = 5'h04, IDX_PARITY = 5'h05;
   localparam logic [4:0] IDX_STOPBITS = 5'h06, IDX_TXWAIT = 5'h07, IDX_START_MD = 5'h08;
   localparam logic [4:0] IDX_EXCITE_MD = 5'h09, IDX_IOSTOP_EN = 5'h0A;
   localparam logic [4:0] IDX_DATANO_MD = 5'h0B, IDX_HFR_MD = 5'h0C;
   localparam logic [4:0] IDX_NONE = 5'h1F;

   // Values after reset.
   localparam logic [15:0] RST_ZERO   = 16'h0000;
   localparam logic [15:0] RST_PARITY = 16'h0001;
   localparam logic [15:0] RST_TXWAIT = 16'h0064;

   // Command word bit positions.
   localparam int CMD_DNO_LSB = 0;
   localparam int CMD_START   = 8;
   localparam int CMD_FWD     = 9;
   localparam int CMD_RVS     = 10;
   localparam int CMD_HOME    = 11;
   localparam int CMD_STOP    = 12;
   localparam int CMD_CON     = 13;

   // Discrete pin vector positions after synchronisation.
   localparam int PIN_W      = 14;
   localparam int PIN_DNO    = 0;
   localparam int PIN_START  = 6;
   localparam int PIN_AWO    = 7;
   localparam int PIN_STOP   = 8;
   localparam int PIN_HOME   = 9;
   localparam int PIN_FWD    = 10;
   localparam int PIN_RVS    = 11;
   localparam int PIN_FCLR   = 12;
   localparam int PIN_PRESET = 13;

   typedef enum logic [2:0] {
      MBRS_RECV,
      MBRS_CHECK,
      MBRS_EXEC,
      MBRS_WAIT,
      MBRS_SEND
   } mbrs_state_e;

endpackage

//--- core/mbrs_sync.sv
/*
 Three-stage synchroniser for the discrete control inputs.
 Assumes inputs arrive from pins outside the mclk domain; a change is taken
 once the second and third stages agree.
*/
`timescale 1ns/1ps
module mbrs_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         mclk,
   input  wire logic         nrst,
   // Data.
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } mbrs_sync_s;

   mbrs_sync_s s;
   mbrs_sync_s next_s;

   always_comb begin
      next_s    = s;
      next_s.s1 = d;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      // Stage one feeds only stage two; the filter looks at stages two and three.
      next_s.q  = (s.s2 & s.s3) | (s.q & (s.s2 ^ s.s3));
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.q;
endmodule

//--- core/mbrs_handler.sv
/*
 Function handler for the serial register protocol of a stepping-motor
 driver: read, single write, diagnosis echo and multiple write, plus the
 serial framing settings and the selection of discrete or serial control.
 Assumes the serial layer delivers each query as bytes from the function code
 onward with rx_last on the final byte, after address match and CRC check, and
 appends address and CRC to each response byte stream it takes.
*/
`timescale 1ns/1ps

module mbrs_handler #(
   parameter int WAIT_UNIT_CYCLES = mbrs_pkg::WAIT_UNIT_CYCLES
) (
   // Clock and reset.
   input  wire logic       mclk,
   input  wire logic       nrst,
   // Query bytes from the serial layer.
   input  wire logic [7:0] rx_data,
   input  wire logic       rx_valid,
   input  wire logic       rx_last,
   output logic            rx_ready,
   // Response bytes to the serial layer.
   output logic [7:0]      tx_data,
   output logic            tx_valid,
   output logic            tx_last,
   input  wire logic       tx_ready,
   // Discrete control inputs.
   input  wire logic       start_input,
   input  wire logic       all_windings_off_input,
   input  wire logic       stop_input,
   input  wire logic       home_input,
   input  wire logic       forward_continuous_input,
   input  wire logic       reverse_continuous_input,
   input  wire logic       fault_clear_input,
   input  wire logic       position_load_input,
   input  wire logic [5:0] data_number_select,
   // Serial framing settings.
   output logic            gateway_protocol_sel,
   output logic [1:0]      parity_mode,
   output logic            two_stop_bits,
   // Motion commands.
   output logic            start_cmd,
   output logic            excitation_on,
   output logic            stop_cmd,
   output logic            home_cmd,
   output logic            forward_continuous_cmd,
   output logic            reverse_continuous_cmd,
   output logic            fault_clear_cmd,
   output logic            position_load_cmd,
   output logic [5:0]      data_number,
   output logic [15:0]     winding_current_setting
);
   typedef struct packed {
      mbrs_pkg::mbrs_state_e                 state;
      logic [mbrs_pkg::BUF_BYTES-1:0][7:0]   qbuf;
      logic [4:0]                            len;
      logic                                  ovf;
      logic [3:0]                            idx;
      logic [3:0]                            nreg;
      logic [15:0]                           addr;
      logic [7:0]                            exc;
      logic [mbrs_pkg::NREG-1:0][15:0]       regs;
      logic [31:0]                           tick;
      logic [15:0]                           units;
      logic [4:0]                            tx_idx;
      logic [4:0]                            tx_len;
      logic [7:0]                            tx_data;
      logic                                  fclr_pulse;
      logic                                  preset_pulse;
      logic [13:0]                           outs;
   } mbrs_main_s;

   mbrs_main_s                    s;
   mbrs_main_s                    next_s;
   logic [mbrs_pkg::PIN_W-1:0]    pin_raw;
   logic [mbrs_pkg::PIN_W-1:0]    pin;

   assign pin_raw = {position_load_input, fault_clear_input, reverse_continuous_input,
                     forward_continuous_input, home_input, stop_input,
                     all_windings_off_input, start_input, data_number_select};

   mbrs_sync #(.W(mbrs_pkg::PIN_W)) u_sync (
      .mclk (mclk),
      .nrst (nrst),
      .d    (pin_raw),
      .q    (pin)
   );

   // Maps a register address onto its storage index.
   function automatic logic [4:0] map_index(input logic [15:0] a);
      case (a)
         mbrs_pkg::ADDR_CMD:       map_index = mbrs_pkg::IDX_CMD;
         mbrs_pkg::ADDR_FCLR:      map_index = mbrs_pkg::IDX_FCLR;
         mbrs_pkg::ADDR_PRESET:    map_index = mbrs_pkg::IDX_PRESET;
         mbrs_pkg::ADDR_CURRENT:   map_index = mbrs_pkg::IDX_CURRENT;
         mbrs_pkg::ADDR_PROTOCOL:  map_index = mbrs_pkg::IDX_PROTOCOL;
         mbrs_pkg::ADDR_PARITY:    map_index = mbrs_pkg::IDX_PARITY;
         mbrs_pkg::ADDR_STOPBITS:  map_index = mbrs_pkg::IDX_STOPBITS;
         mbrs_pkg::ADDR_TXWAIT:    map_index = mbrs_pkg::IDX_TXWAIT;
         mbrs_pkg::ADDR_START_MD:  map_index = mbrs_pkg::IDX_START_MD;
         mbrs_pkg::ADDR_EXCITE_MD: map_index = mbrs_pkg::IDX_EXCITE_MD;
         mbrs_pkg::ADDR_IOSTOP_EN: map_index = mbrs_pkg::IDX_IOSTOP_EN;
         mbrs_pkg::ADDR_DATANO_MD: map_index = mbrs_pkg::IDX_DATANO_MD;
         mbrs_pkg::ADDR_HFR_MD:    map_index = mbrs_pkg::IDX_HFR_MD;
         default:                  map_index = mbrs_pkg::IDX_NONE;
      endcase
   endfunction

   // Settings outside their range are refused one by one.
   function automatic logic range_ok(input logic [4:0] k, input logic [15:0] v);
      case (k)
         mbrs_pkg::IDX_PARITY:   range_ok = (v <= 16'h0002);
         mbrs_pkg::IDX_TXWAIT:   range_ok = (v <= mbrs_pkg::WAIT_MAX_UNITS);
         mbrs_pkg::IDX_CMD, mbrs_pkg::IDX_FCLR, mbrs_pkg::IDX_PRESET,
         mbrs_pkg::IDX_CURRENT:  range_ok = 1'b1;
         default:                range_ok = (v <= 16'h0001);
      endcase
   endfunction

   // Produces response byte i from the executed query.
   function automatic logic [7:0] resp_byte(input mbrs_main_s st, input logic [4:0] i);
      logic [15:0] word;
      logic [4:0]  k;
      word = '0;
      k    = '0;
      if (st.exc != mbrs_pkg::EXC_NONE) begin
         resp_byte = (i == 5'h00) ? (st.qbuf[0] | mbrs_pkg::FC_EXC) : st.exc;
      end else if (st.qbuf[0] == mbrs_pkg::FC_READ) begin
         if (i == 5'h00) begin
            resp_byte = st.qbuf[0];
         end else if (i == 5'h01) begin
            resp_byte = {3'h0, st.nreg, 1'b0};
         end else begin
            // Upper byte first, registers in ascending order.
            k    = map_index(st.addr + 16'((i - 5'h02) >> 1));
            word = (k < 5'(mbrs_pkg::NREG)) ? st.regs[k] : 16'h0000;
            resp_byte = i[0] ? word[7:0] : word[15:8];
         end
      end else begin
         resp_byte = st.qbuf[i];
      end
   endfunction

   always_comb begin
      logic [15:0] cnt;
      logic [15:0] val;
      logic [4:0]  k;
      logic [4:0]  p;
      logic        done;
      cnt  = {s.qbuf[3], s.qbuf[4]};
      val  = '0;
      k    = '0;
      p    = '0;
      done = 1'b0;
      next_s              = s;
      next_s.fclr_pulse   = 1'b0;
      next_s.preset_pulse = 1'b0;
      unique case (s.state)
         mbrs_pkg::MBRS_RECV: begin
            if (rx_valid) begin
               if (s.len < 5'(mbrs_pkg::BUF_BYTES)) begin
                  next_s.qbuf[s.len] = rx_data;
                  next_s.len         = s.len + 5'h01;
               end else begin
                  next_s.ovf = 1'b1;
               end
               if (rx_last) begin
                  next_s.state = mbrs_pkg::MBRS_CHECK;
               end
            end
         end
         mbrs_pkg::MBRS_CHECK: begin
            next_s.addr   = {s.qbuf[1], s.qbuf[2]};
            next_s.idx    = '0;
            next_s.exc    = mbrs_pkg::EXC_NONE;
            next_s.tx_len = mbrs_pkg::ECHO_LEN;
            next_s.state  = mbrs_pkg::MBRS_EXEC;
            case (s.qbuf[0])
               mbrs_pkg::FC_READ: begin
                  if (cnt == 16'h0000 || cnt > mbrs_pkg::MAX_REGS ||
                      s.len != mbrs_pkg::ECHO_LEN) begin
                     next_s.exc = mbrs_pkg::EXC_DATA;
                  end
                  next_s.nreg   = cnt[3:0];
                  next_s.tx_len = 5'h02 + {cnt[3:0], 1'b0};
               end
               mbrs_pkg::FC_WRITE1: begin
                  next_s.nreg = 4'h1;
                  if (s.len != mbrs_pkg::ECHO_LEN) begin
                     next_s.exc = mbrs_pkg::EXC_DATA;
                  end
               end
               mbrs_pkg::FC_DIAG: begin
                  // Only the subfunction word is judged; the data word is echoed as sent.
                  if (s.qbuf[1] != 8'h00 || s.qbuf[2] != 8'h00) begin
                     next_s.exc = mbrs_pkg::EXC_FUNC;
                  end else if (s.len != mbrs_pkg::ECHO_LEN) begin
                     next_s.exc = mbrs_pkg::EXC_DATA;
                  end
                  next_s.state = mbrs_pkg::MBRS_WAIT;
               end
               mbrs_pkg::FC_WRITEN: begin
                  next_s.nreg = cnt[3:0];
                  if (cnt == 16'h0000 || cnt > mbrs_pkg::MAX_REGS || s.ovf ||
                      s.qbuf[5] != {cnt[6:0], 1'b0} ||
                      s.len != mbrs_pkg::MULTI_HDR + {cnt[3:0], 1'b0}) begin
                     next_s.exc = mbrs_pkg::EXC_DATA;
                  end
               end
               default: next_s.exc = mbrs_pkg::EXC_FUNC;
            endcase
            if (next_s.exc != mbrs_pkg::EXC_NONE) begin
               next_s.tx_len = mbrs_pkg::EXC_LEN;
               next_s.state  = mbrs_pkg::MBRS_WAIT;
            end
            // Gateway protocol frames are not served here and get no reply.
            if (s.regs[mbrs_pkg::IDX_PROTOCOL][0]) begin
               next_s.state = mbrs_pkg::MBRS_RECV;
               next_s.len   = '0;
               next_s.ovf   = 1'b0;
            end
            next_s.units = s.regs[mbrs_pkg::IDX_TXWAIT];
            next_s.tick  = '0;
         end
         mbrs_pkg::MBRS_EXEC: begin
            // One register per cycle in ascending address order.
            k    = map_index(s.addr + 16'(s.idx));
            p    = 5'h06 + {s.idx, 1'b0};
            val  = (s.qbuf[0] == mbrs_pkg::FC_WRITE1) ? cnt : {s.qbuf[p], s.qbuf[p + 5'h01]};
            done = (s.idx + 4'h1 == s.nreg);
            if (k == mbrs_pkg::IDX_NONE) begin
               next_s.exc = mbrs_pkg::EXC_ADDR;
               done       = 1'b1;
            end else if (s.qbuf[0] != mbrs_pkg::FC_READ) begin
               if (range_ok(k, val)) begin
                  next_s.regs[k] = val;
                  next_s.fclr_pulse   = (k == mbrs_pkg::IDX_FCLR) && val[0];
                  next_s.preset_pulse = (k == mbrs_pkg::IDX_PRESET) && val[0];
               end else begin
                  // Earlier and later registers of the query stay written.
                  next_s.exc = mbrs_pkg::EXC_DATA;
               end
            end
            next_s.idx = s.idx + 4'h1;
            if (done) begin
               next_s.state = mbrs_pkg::MBRS_WAIT;
               if (next_s.exc != mbrs_pkg::EXC_NONE) begin
                  next_s.tx_len = mbrs_pkg::EXC_LEN;
               end
            end
         end
         mbrs_pkg::MBRS_WAIT: begin
            if (s.units == 16'h0000) begin
               next_s.state   = mbrs_pkg::MBRS_SEND;
               next_s.tx_idx  = '0;
               next_s.tx_data = resp_byte(s, 5'h00);
            end else if (s.tick == 32'(WAIT_UNIT_CYCLES - 1)) begin
               next_s.tick  = '0;
               next_s.units = s.units - 16'h0001;
            end else begin
               next_s.tick = s.tick + 32'h1;
            end
         end
         mbrs_pkg::MBRS_SEND: begin
            if (tx_ready) begin
               if (s.tx_idx + 5'h01 == s.tx_len) begin
                  next_s.state = mbrs_pkg::MBRS_RECV;
                  next_s.len   = '0;
                  next_s.ovf   = 1'b0;
               end else begin
                  next_s.tx_idx  = s.tx_idx + 5'h01;
                  next_s.tx_data = resp_byte(s, s.tx_idx + 5'h01);
               end
            end
         end
      endcase

      // Control source selection; mode value 0 keeps the discrete pin, except stop, where IDX_IOSTOP_EN value 0 ignores the stop pin.
      next_s.outs[0] = s.regs[mbrs_pkg::IDX_START_MD][0] ?
                       s.regs[mbrs_pkg::IDX_CMD][mbrs_pkg::CMD_START] :
                       pin[mbrs_pkg::PIN_START];
      next_s.outs[1] = s.regs[mbrs_pkg::IDX_EXCITE_MD][0] ?
                       s.regs[mbrs_pkg::IDX_CMD][mbrs_pkg::CMD_CON] :
                       !pin[mbrs_pkg::PIN_AWO];
      next_s.outs[2] = s.regs[mbrs_pkg::IDX_CMD][mbrs_pkg::CMD_STOP] |
                       (s.regs[mbrs_pkg::IDX_IOSTOP_EN][0] & pin[mbrs_pkg::PIN_STOP]);
      next_s.outs[3] = s.regs[mbrs_pkg::IDX_HFR_MD][0] ?
                       s.regs[mbrs_pkg::IDX_CMD][mbrs_pkg::CMD_HOME] :
                       pin[mbrs_pkg::PIN_HOME];
      next_s.outs[4] = s.regs[mbrs_pkg::IDX_HFR_MD][0] ?
                       s.regs[mbrs_pkg::IDX_CMD][mbrs_pkg::CMD_FWD] :
                       pin[mbrs_pkg::PIN_FWD];
      next_s.outs[5] = s.regs[mbrs_pkg::IDX_HFR_MD][0] ?
                       s.regs[mbrs_pkg::IDX_CMD][mbrs_pkg::CMD_RVS] :
                       pin[mbrs_pkg::PIN_RVS];
      next_s.outs[6] = pin[mbrs_pkg::PIN_FCLR] | s.fclr_pulse;
      next_s.outs[7] = pin[mbrs_pkg::PIN_PRESET] | s.preset_pulse;
      next_s.outs[13:8] = s.regs[mbrs_pkg::IDX_DATANO_MD][0] ?
                          s.regs[mbrs_pkg::IDX_CMD][mbrs_pkg::CMD_DNO_LSB +: 6] :
                          pin[mbrs_pkg::PIN_DNO +: 6];
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s                             <= '0;
         s.state                       <= mbrs_pkg::MBRS_RECV;
         s.regs[mbrs_pkg::IDX_PARITY]  <= mbrs_pkg::RST_PARITY;
         s.regs[mbrs_pkg::IDX_TXWAIT]  <= mbrs_pkg::RST_TXWAIT;
         s.regs[mbrs_pkg::IDX_STOPBITS] <= mbrs_pkg::RST_ZERO;
         s.regs[mbrs_pkg::IDX_PROTOCOL] <= mbrs_pkg::RST_ZERO;
      end else begin
         s <= next_s;
      end
   end

   assign rx_ready                = (s.state == mbrs_pkg::MBRS_RECV);
   assign tx_valid                = (s.state == mbrs_pkg::MBRS_SEND);
   assign tx_last                 = tx_valid && (s.tx_idx + 5'h01 == s.tx_len);
   assign tx_data                 = s.tx_data;
   assign gateway_protocol_sel    = s.regs[mbrs_pkg::IDX_PROTOCOL][0];
   assign parity_mode             = s.regs[mbrs_pkg::IDX_PARITY][1:0];
   assign two_stop_bits           = s.regs[mbrs_pkg::IDX_STOPBITS][0];
   assign start_cmd               = s.outs[0];
   assign excitation_on           = s.outs[1];
   assign stop_cmd                = s.outs[2];
   assign home_cmd                = s.outs[3];
   assign forward_continuous_cmd  = s.outs[4];
   assign reverse_continuous_cmd  = s.outs[5];
   assign fault_clear_cmd         = s.outs[6];
   assign position_load_cmd       = s.outs[7];
   assign data_number             = s.outs[13:8];
   assign winding_current_setting = s.regs[mbrs_pkg::IDX_CURRENT];
endmodule

//--- tb/mbrs_monitor.sv
/* Port checker for the serial function handler.
   Assumes it is bound to mbrs_handler and sees only its ports. */
`timescale 1ns/1ps
module mbrs_monitor (
   // Clock and reset.
   input wire logic       mclk,
   input wire logic       nrst,
   // Byte streams.
   input wire logic       rx_valid,
   input wire logic       rx_last,
   input wire logic       rx_ready,
   input wire logic [7:0] tx_data,
   input wire logic       tx_valid,
   input wire logic       tx_last,
   input wire logic       tx_ready,
   // Framing setting.
   input wire logic [1:0] parity_mode
);
   logic [4:0] cnt;
   logic [7:0] fc;
   logic [7:0] bc;
   // Index of the reply byte on offer, and the first two bytes already taken.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 5'h00;
         fc  <= 8'h00;
         bc  <= 8'h00;
      end else if (tx_valid && tx_ready) begin
         cnt <= tx_last ? 5'h00 : cnt + 5'h01;
         fc  <= (cnt == 5'h00) ? tx_data : fc;
         bc  <= (cnt == 5'h01) ? tx_data : bc;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_last_in; rx_valid && rx_ready && rx_last; endsequence
   sequence s_exc_head; tx_valid && tx_ready && cnt == 5'h00 && tx_data[7]; endsequence
   property p_wait_min; s_last_in |=> !tx_valid [*2]; endproperty
   property p_exc_shape;
      s_exc_head |=> tx_valid && tx_last && tx_data inside {8'h01, 8'h02, 8'h03};
   endproperty
   property p_echo_len;
      tx_valid && tx_last && cnt != 5'h00 && fc inside {8'h06, 8'h08, 8'h10} |-> cnt == 5'h04;
   endproperty
   property p_read_len;
      tx_valid && tx_last && cnt > 5'h01 && fc == 8'h03 |-> cnt == bc[4:0] + 5'h01;
   endproperty
   property p_read_count;
      tx_valid && cnt == 5'h01 && fc == 8'h03 |-> tx_data != 8'h00 && tx_data <= 8'h14;
   endproperty
   property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   property p_rx_busy; tx_valid |-> !rx_ready; endproperty
   property p_parity; parity_mode != 2'h3; endproperty
   a_wait_min: assert property (p_wait_min)
      else $error("reply came too early");
   a_exc_shape: assert property (p_exc_shape)
      else $error("bad exception reply");
   a_echo_len: assert property (p_echo_len)
      else $error("echo length wrong");
   a_read_len: assert property (p_read_len)
      else $error("read length wrong");
   a_read_count: assert property (p_read_count)
      else $error("read count out of range");
   a_tx_hold: assert property (p_tx_hold)
      else $error("reply byte changed while stalled");
   a_rx_busy: assert property (p_rx_busy)
      else $error("query taken during reply");
   a_parity: assert property (p_parity)
      else $error("illegal parity mode");
endmodule
bind mbrs_handler mbrs_monitor mon (.mclk(mclk), .nrst(nrst), .rx_valid(rx_valid),
   .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
   .tx_last(tx_last), .tx_ready(tx_ready), .parity_mode(parity_mode));

//--- tb/mbrs_master_model.sv
/* Bus master model that offers query bytes and takes reply bytes.
   Assumes the handler clock; it drives 1 ns after each rising edge. */
`timescale 1ns/1ps
module mbrs_master_model (
   // Clock.
   input wire logic       mclk,
   // Query side.
   output logic [7:0]     rx_data,
   output logic           rx_valid,
   output logic           rx_last,
   input wire logic       rx_ready,
   // Reply side.
   input wire logic [7:0] tx_data,
   input wire logic       tx_valid,
   input wire logic       tx_last,
   output logic           tx_ready
);
   logic [7:0] rsp[$];
   int         dly;
   initial begin
      rx_data  = 8'h00;
      rx_valid = 1'b0;
      rx_last  = 1'b0;
      tx_ready = 1'b0;
   end
   task automatic query(input logic [7:0] q[$], input bit slow);
      int n;
      bit done;
      rsp.delete();
      foreach (q[i]) begin
         rx_data  = q[i];
         rx_valid = 1'b1;
         rx_last  = (i == q.size() - 1);
         while (!rx_ready) @(posedge mclk) #1;
         @(posedge mclk) #1;
      end
      rx_valid = 1'b0;
      rx_last  = 1'b0;
      rx_data  = ~rx_data;
      done = 1'b0;
      dly  = 0;
      for (n = 0; n < 6000 && !done; n++) begin
         tx_ready = slow ? n[0] : 1'b1;
         if (tx_valid && dly == 0) dly = n;
         if (tx_valid && tx_ready) begin
            rsp.push_back(tx_data);
            done = tx_last;
         end
         @(posedge mclk) #1;
      end
   endtask
endmodule

//--- tb/tb_mbrs_handler.sv
/* Self-checking bench for the serial function handler.
   Assumes the master model and the bound checker. */
`timescale 1ns/1ps
module tb_mbrs_handler;
   logic        mclk, nrst, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
   logic        gateway_protocol_sel, two_stop_bits, start_cmd, excitation_on, stop_cmd;
   logic        home_cmd, forward_continuous_cmd, reverse_continuous_cmd;
   logic        fault_clear_cmd, position_load_cmd;
   logic [7:0]  rx_data, tx_data, pin;
   logic [1:0]  parity_mode;
   logic [5:0]  data_number, data_number_select;
   logic [15:0] winding_current_setting;
   int          num_errors, tests_run, cyc, pulses, p0;
   mbrs_handler #(.WAIT_UNIT_CYCLES(4)) dut (.*, .start_input(pin[0]),
      .all_windings_off_input(pin[1]), .stop_input(pin[2]), .home_input(pin[3]),
      .forward_continuous_input(pin[4]), .reverse_continuous_input(pin[5]),
      .fault_clear_input(pin[6]), .position_load_input(pin[7]));
   mbrs_master_model master (.*);
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      pulses <= pulses + int'(fault_clear_cmd) + int'(position_load_cmd);
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xq(input logic [7:0] b[$], input logic [7:0] e[$]);
      master.query(b, tests_run[0]);
      chk(master.rsp.size(), e.size());
      foreach (e[i]) chk(master.rsp[i], e[i]);
   endtask
   task automatic wr1(input logic [15:0] a, input logic [15:0] v);
      xq('{8'h06, a[15:8], a[7:0], v[15:8], v[7:0]},
         '{8'h06, a[15:8], a[7:0], v[15:8], v[7:0]});
   endtask
   task automatic t_defaults();
      chk({gateway_protocol_sel, parity_mode, two_stop_bits}, 4'h2);
      xq('{8'h03, 8'h03, 8'h80, 8'h00, 8'h04}, '{8'h03, 8'h08, 8'h00, 8'h00, 8'h00,
         8'h01, 8'h00, 8'h00, 8'h00, 8'h64});
      chk(master.dly >= 400 && master.dly <= 412, 1);
      $display("done: defaults");
   endtask
   task automatic t_writes();
      wr1(16'h021E, 16'h0050);
      chk(winding_current_setting, 16'h0050);
      wr1(16'h0383, 16'h0000);
      xq('{8'h10, 8'h03, 8'h81, 8'h00, 8'h02, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01},
         '{8'h10, 8'h03, 8'h81, 8'h00, 8'h02});
      chk({parity_mode, two_stop_bits}, 3'h5);
      xq('{8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, '{8'h08, 8'h00, 8'h00, 8'h12, 8'h34});
      chk(master.dly <= 12, 1);
      $display("done: writes");
   endtask
   task automatic t_errors();
      xq('{8'h10, 8'h03, 8'h81, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h05},
         '{8'h90, 8'h03});
      chk(parity_mode, 2'h0);
      xq('{8'h10, 8'h03, 8'h81, 8'h00, 8'h00, 8'h00}, '{8'h90, 8'h03});
      xq('{8'h10, 8'h03, 8'h81, 8'h00, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00},
         '{8'h90, 8'h03});
      xq('{8'h03, 8'h03, 8'h80, 8'h00, 8'h0B}, '{8'h83, 8'h03});
      xq('{8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, '{8'h88, 8'h01});
      xq('{8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h87, 8'h01});
      $display("done: errors");
   endtask
   task automatic t_control();
      pin = 8'hC2;
      data_number_select = 6'h2A;
      repeat (8) @(posedge mclk) #1;
      chk({excitation_on, data_number}, 7'h2A);
      chk({fault_clear_cmd, position_load_cmd}, 2'h3);
      pin = 8'h00;
      xq('{8'h10, 8'h03, 8'h84, 8'h00, 8'h05, 8'h0A, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00,
         8'h01, 8'h00, 8'h01, 8'h00, 8'h01}, '{8'h10, 8'h03, 8'h84, 8'h00, 8'h05});
      wr1(16'h001E, 16'h2B15);
      repeat (4) @(posedge mclk) #1;
      chk({start_cmd, excitation_on, home_cmd, forward_continuous_cmd,
         reverse_continuous_cmd, data_number}, {5'h1E, 6'h15});
      wr1(16'h001E, 16'h1000);
      repeat (4) @(posedge mclk) #1;
      chk(stop_cmd, 1'b1);
      p0 = pulses;
      wr1(16'h0040, 16'h0001);
      wr1(16'h0048, 16'h0001);
      chk(pulses - p0, 2);
      master.query('{8'h06, 8'h03, 8'h80, 8'h00, 8'h01}, 1'b0);
      chk(gateway_protocol_sel, 1'b1);
      $display("done: control");
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      nrst = 1'b0;
      pin = 8'h00;
      data_number_select = 6'h00;
      repeat (12) @(posedge mclk);
      #1 nrst = 1'b1;
      @(posedge mclk) #1;
      t_defaults();
      t_writes();
      t_errors();
      t_control();
      stop_test();
   end
endmodule
